// ==== hw/dmac_cfg.svh ====
// Register offsets, field positions and timing constants of the DMA block
`ifndef DMAC_CFG_SVH
`define DMAC_CFG_SVH
`define DMAC_PORT_COMMAND 4'h8
`define DMAC_PORT_REQUEST 4'h9
`define DMAC_PORT_MASK1 4'ha
`define DMAC_PORT_MODE 4'hb
`define DMAC_PORT_CLRPTR 4'hc
`define DMAC_PORT_MCLEAR 4'hd
`define DMAC_CMD_MEM2MEM 0
`define DMAC_CMD_HOLD0 1
`define DMAC_CMD_DISABLE 2
`define DMAC_CMD_COMPRESS 3
`define DMAC_CMD_ROTATE 4
`define DMAC_CMD_EXTWR 5
`define DMAC_CMD_REQLOW 6
`define DMAC_CMD_ACKHIGH 7
`define DMAC_SEL_SET 2
`define DMAC_MASK_RESET 4'hf
`define DMAC_REFRESH_ROWS 8'hff
`define DMAC_XFER_CYCLES 3'h3
`define DMAC_XFER_CYCLES_FAST 3'h1
`endif

// ==== hw/dmac_pkg.sv ====
// Types shared by the DMA register interface
package dmac_pkg;
  typedef struct packed {
    logic [15:0] base_addr;
    logic [15:0] cur_addr;
    logic [15:0] base_count;
    logic [15:0] cur_count;
    logic [5:0] mode;
  } dmac_chan_t;
  typedef enum logic [1:0] {DMAC_IDLE, DMAC_XFER, DMAC_DONE} dmac_phase_t;
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [15:0] addr;
    logic last;
  } dmac_xfer_t;
  typedef struct packed {
    dmac_chan_t [3:0] chan;
    logic [7:0] command;
    logic [3:0] tc_flag;
    logic [3:0] sw_req;
    logic [3:0] mask;
    logic byte_ptr;
    logic [7:0] temp;
    logic [7:0] read_data;
    logic [7:0] refresh_row;
    logic refresh_pending;
    logic [2:0] tsync;
    logic [2:0] wsync;
    logic [2:0] rsync;
    logic [3:0] req_q1;
    logic [3:0] req_q2;
    logic [3:0] req_q3;
    logic [3:0] req_level;
    dmac_phase_t phase;
    logic [1:0] active;
    logic [1:0] last_served;
    logic [2:0] cycle_cnt;
    dmac_xfer_t [1:0] buf_q;
    logic [3:0] ack;
  } dmac_state_t;
endpackage

// ==== hw/dmac_regs.sv ====
// Four-channel DMA controller register interface and transfer sequencer
// Operation
// - Even port write loads address byte
// - Odd port write loads count byte
// - Address read returns current address byte
// - Count read returns current count byte
// - Command bit0 enables memory-to-memory
// - Bit1 holds channel 0 address when bit0 is also set
// - Bit2 stops new transfers starting; refresh and register access keep running
// - Bit3 selects compressed timing unless bit0 is set
// - Bit4 selects rotating priority
// - Bit5 selects extended write strobe unless bit3 is set
// - Bit6 makes requests active low
// - Bit7 makes acknowledges active high
// - Status read: TC and request flags
// - Port 9 sets/clears software request
// - Port A bit2 zero clears mask
// - Port A bit2 one sets mask
// - Port C clears byte pointer
// - Port D master clear; read temporary
// - Port B programs channel mode
// - Supply refresh row addresses
// - Refresh paced by timer counter one
`timescale 1ns/1ps
`include "dmac_cfg.svh"

module dmac_regs
  import dmac_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [3:0] io_address_in,
  input wire logic [7:0] io_data_in,
  input wire logic io_write_strobe_n_in,
  input wire logic io_read_strobe_n_in,
  output logic [7:0] io_data_out,
  output logic io_data_oe_n_out,
  input wire logic [3:0] channel_request_in,
  output logic [3:0] channel_acknowledge_out,
  input wire logic refresh_tick_in,
  output logic [7:0] refresh_row_out,
  output logic refresh_strobe_out,
  output logic xfer_valid_out,
  input wire logic xfer_ready_in,
  output logic [1:0] xfer_channel_out,
  output logic [15:0] xfer_address_out,
  output logic xfer_last_out,
  output logic mem_write_extended_out,
  output logic mem_timing_compressed_out
);

  dmac_state_t st;
  dmac_state_t next_st;
  logic wr_edge;
  logic rd_edge;
  logic tick_edge;
  logic [3:0] req_eff;
  logic [3:0] pending;
  logic [1:0] pick;
  logic pick_ok;
  logic buf_push;
  logic buf_pop;
  logic buf_full;
  logic [1:0] ch_idx;
  logic [7:0] wdata;

  // Byte select by pointer: low byte at 0, high byte at 1
  function automatic logic [7:0] pick_byte(input logic [15:0] v,
                                           input logic hi);
    pick_byte = hi ? v[15:8] : v[7:0];
  endfunction

  function automatic logic [15:0] put_byte(input logic [15:0] v,
                                           input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction

  // ---------------------------------------------------------------
  // Strobe and pin synchronisers
  // ---------------------------------------------------------------
  // A strobe fall or a tick rise counts once the second and third stages differ
  assign wr_edge = (st.wsync[1] == st.wsync[2]) ? 1'b0 :
                   (~st.wsync[1] & st.wsync[2]);
  assign rd_edge = ~st.rsync[1] & st.rsync[2];
  assign tick_edge = st.tsync[1] & ~st.tsync[2];
  assign ch_idx = io_address_in[2:1];
  assign wdata = io_data_in;

  // Request polarity, then mask and pending software requests
  assign req_eff = (st.command[`DMAC_CMD_REQLOW] ? ~st.req_level :
                    st.req_level) | st.sw_req;
  assign pending = req_eff & ~st.mask;

  // ---------------------------------------------------------------
  // Priority pick
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [1:0] start;
    logic [1:0] c;
    c = 2'h0;
    start = st.command[`DMAC_CMD_ROTATE] ?
            2'(st.last_served + 2'h1) : 2'h0;
    pick = 2'h0;
    pick_ok = 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      c = 2'(start + 2'(i));
      if (pending[c])
      begin
        pick = c;
        pick_ok = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Two-entry output buffer
  // ---------------------------------------------------------------
  assign buf_full = st.buf_q[1].valid;
  assign buf_pop = st.buf_q[0].valid & xfer_ready_in;
  assign buf_push = (st.phase == DMAC_XFER) &&
                    (st.cycle_cnt == 3'h0) && !buf_full;

  always_comb
  begin
    dmac_chan_t ch;
    logic [2:0] xfer_len;
    next_st = st;
    ch = st.chan[st.active];
    xfer_len = (st.command[`DMAC_CMD_COMPRESS] &&
                !st.command[`DMAC_CMD_MEM2MEM]) ?
               `DMAC_XFER_CYCLES_FAST : `DMAC_XFER_CYCLES;
    next_st.wsync = {st.wsync[1:0], io_write_strobe_n_in};
    next_st.rsync = {st.rsync[1:0], io_read_strobe_n_in};
    next_st.tsync = {st.tsync[1:0], refresh_tick_in};
    next_st.req_q1 = channel_request_in;
    next_st.req_q2 = st.req_q1;
    next_st.req_q3 = st.req_q2;
    if (st.req_q2 == st.req_q3)
    begin
      next_st.req_level = st.req_q3;
    end

    // Refresh pacing by the timer's counter one output
    if (tick_edge)
    begin
      next_st.refresh_row = 8'(st.refresh_row + 8'h1);
      next_st.refresh_pending = 1'b1;
    end
    else
    begin
      next_st.refresh_pending = 1'b0;
    end

    // Buffer shift on pop, then append
    if (buf_pop)
    begin
      next_st.buf_q[0] = st.buf_q[1];
      next_st.buf_q[1] = '0;
    end
    if (buf_push)
    begin
      if (buf_pop || !st.buf_q[0].valid)
        next_st.buf_q[0] = '{1'b1, st.active,
          ch.cur_addr, ch.cur_count == 16'h0};
      else
        next_st.buf_q[1] = '{1'b1, st.active, ch.cur_addr,
          ch.cur_count == 16'h0};
      if (buf_pop && st.buf_q[1].valid)
      begin
        next_st.buf_q[0] = st.buf_q[1];
        next_st.buf_q[1] = '{1'b1, st.active, ch.cur_addr,
          ch.cur_count == 16'h0};
      end
    end

    // ---------------------------------------------------------------
    // Transfer sequencer
    // ---------------------------------------------------------------
    next_st.ack = 4'h0;
    case (st.phase)
      DMAC_IDLE:
      begin
        next_st.cycle_cnt = xfer_len;
        if (!st.command[`DMAC_CMD_DISABLE] && pick_ok)
        begin
          next_st.active = pick;
          next_st.phase = DMAC_XFER;
        end
      end
      DMAC_XFER:
      begin
        next_st.ack[st.active] = 1'b1;
        if (st.cycle_cnt != 3'h0)
          next_st.cycle_cnt = 3'(st.cycle_cnt - 3'h1);
        else if (buf_push)
        begin
          // Channel 0 address hold only counts in memory-to-memory
          if (!(st.active == 2'h0 && st.command[`DMAC_CMD_MEM2MEM] &&
                st.command[`DMAC_CMD_HOLD0]))
            next_st.chan[st.active].cur_addr = ch.mode[3] ?
              16'(ch.cur_addr - 16'h1) : 16'(ch.cur_addr + 16'h1);
          next_st.chan[st.active].cur_count = 16'(ch.cur_count - 16'h1);
          next_st.cycle_cnt = xfer_len;
          if (ch.cur_count == 16'h0)
          begin
            next_st.tc_flag[st.active] = 1'b1;
            next_st.sw_req[st.active] = 1'b0;
            if (ch.mode[2])
            begin
              next_st.chan[st.active].cur_addr = ch.base_addr;
              next_st.chan[st.active].cur_count = ch.base_count;
            end
            else
              next_st.mask[st.active] = 1'b1;
            next_st.phase = DMAC_DONE;
          end
          else if (ch.mode[5:4] == 2'h1 || !pending[st.active])
            next_st.phase = DMAC_DONE;
        end
      end
      DMAC_DONE:
      begin
        next_st.last_served = st.active;
        next_st.phase = DMAC_IDLE;
      end
      default:
        next_st.phase = DMAC_IDLE;
    endcase

    // ---------------------------------------------------------------
    // Register port decode
    // ---------------------------------------------------------------
    if (rd_edge)
    begin
      if (!io_address_in[3])
      begin
        next_st.read_data = io_address_in[0] ?
          pick_byte(st.chan[ch_idx].cur_count, st.byte_ptr) :
          pick_byte(st.chan[ch_idx].cur_addr, st.byte_ptr);
        next_st.byte_ptr = ~st.byte_ptr;
      end
      else if (io_address_in == `DMAC_PORT_COMMAND)
      begin
        // Request bits show polarity-corrected requests plus software requests, masked or not
        next_st.read_data = {req_eff, st.tc_flag};
        // Only flags already seen are cleared; a same-cycle terminal
        // count survives the read
        next_st.tc_flag = next_st.tc_flag & ~st.tc_flag;
      end
      else if (io_address_in == `DMAC_PORT_MCLEAR)
        next_st.read_data = st.temp;
      else
        next_st.read_data = 8'h00;
    end
    if (wr_edge)
    begin
      if (!io_address_in[3])
      begin
        if (io_address_in[0])
        begin
          next_st.chan[ch_idx].base_count = put_byte(
            st.chan[ch_idx].base_count, st.byte_ptr, wdata);
          next_st.chan[ch_idx].cur_count = put_byte(
            st.chan[ch_idx].cur_count, st.byte_ptr, wdata);
        end
        else
        begin
          next_st.chan[ch_idx].base_addr = put_byte(
            st.chan[ch_idx].base_addr, st.byte_ptr, wdata);
          next_st.chan[ch_idx].cur_addr = put_byte(
            st.chan[ch_idx].cur_addr, st.byte_ptr, wdata);
        end
        next_st.byte_ptr = ~st.byte_ptr;
      end
      else
      begin
        case (io_address_in)
          `DMAC_PORT_COMMAND: next_st.command = wdata;
          `DMAC_PORT_REQUEST:
            next_st.sw_req[wdata[1:0]] = wdata[`DMAC_SEL_SET];
          `DMAC_PORT_MASK1:
            next_st.mask[wdata[1:0]] = wdata[`DMAC_SEL_SET];
          `DMAC_PORT_MODE:
            next_st.chan[wdata[1:0]].mode = wdata[7:2];
          `DMAC_PORT_CLRPTR: next_st.byte_ptr = 1'b0;
          `DMAC_PORT_MCLEAR:
          begin
            next_st.command = 8'h00;
            next_st.tc_flag = 4'h0;
            next_st.sw_req = 4'h0;
            next_st.mask = `DMAC_MASK_RESET;
            next_st.byte_ptr = 1'b0;
            next_st.temp = 8'h00;
            next_st.phase = DMAC_IDLE;
            next_st.ack = 4'h0;
          end
          default: next_st.temp = st.temp;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      st <= '0;
      st.mask <= `DMAC_MASK_RESET;
      st.wsync <= 3'h7;
      st.rsync <= 3'h7;
      st.phase <= DMAC_IDLE;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign io_data_out = st.read_data;
  assign io_data_oe_n_out = io_read_strobe_n_in;
  assign channel_acknowledge_out = st.command[`DMAC_CMD_ACKHIGH] ?
                                   st.ack : ~st.ack;
  assign refresh_row_out = st.refresh_row;
  assign refresh_strobe_out = st.refresh_pending;
  assign xfer_valid_out = st.buf_q[0].valid;
  assign xfer_channel_out = st.buf_q[0].chan;
  assign xfer_address_out = st.buf_q[0].addr;
  assign xfer_last_out = st.buf_q[0].last;
  // Extended write is meaningless under compressed timing
  assign mem_write_extended_out = st.command[`DMAC_CMD_EXTWR] &
                                  ~st.command[`DMAC_CMD_COMPRESS];
  assign mem_timing_compressed_out = st.command[`DMAC_CMD_COMPRESS] &
                                     ~st.command[`DMAC_CMD_MEM2MEM];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  ptr_toggle_a: assert property (wr_edge && !io_address_in[3] |=>
    st.byte_ptr != $past(st.byte_ptr)) else $error("pointer stuck");
  ptr_clear_a: assert property (wr_edge && io_address_in ==
    `DMAC_PORT_CLRPTR |=> !st.byte_ptr) else $error("pointer not cleared");
  addr_write_a: assert property (wr_edge && io_address_in == 4'h0
    && !st.byte_ptr |=> st.chan[0].cur_addr[7:0] == $past(io_data_in))
    else $error("address low byte not loaded");
  status_read_a: assert property (rd_edge && io_address_in ==
    `DMAC_PORT_COMMAND |=> st.read_data[3:0] == $past(st.tc_flag))
    else $error("status wrong");
  mask_set_a: assert property (wr_edge && io_address_in ==
    `DMAC_PORT_MASK1 && io_data_in[2] |=> st.mask[$past(io_data_in[1:0])])
    else $error("mask not set");
  disable_hold_a: assert property (st.command[`DMAC_CMD_DISABLE] &&
    st.phase == DMAC_IDLE && !wr_edge |=> st.phase == DMAC_IDLE)
    else $error("transfer while disabled");
  ack_pol_a: assert property (!st.command[`DMAC_CMD_ACKHIGH] &&
    st.phase == DMAC_IDLE |-> channel_acknowledge_out == 4'hf)
    else $error("ack polarity");
  refresh_a: assert property (tick_edge |=> refresh_strobe_out &&
    refresh_row_out == 8'($past(refresh_row_out) + 8'h1))
    else $error("refresh not paced");
  hold_full_a: assert property (buf_full && !xfer_ready_in |=>
    $stable(xfer_address_out)) else $error("buffer lost word");
  xfer_c: cover property (st.phase == DMAC_XFER ##[1:20] xfer_last_out);
  stall_c: cover property (buf_full && !xfer_ready_in);
  mclear_c: cover property (wr_edge && io_address_in == `DMAC_PORT_MCLEAR);
  hold0_a: assert property (buf_push && st.active == 2'h0 &&
    st.command[`DMAC_CMD_MEM2MEM] && st.command[`DMAC_CMD_HOLD0] &&
    !st.chan[0].mode[2] && !wr_edge |=>
    st.chan[0].cur_addr == $past(st.chan[0].cur_addr))
    else $error("channel 0 address moved");
  auto_c: cover property (buf_push && st.chan[st.active].mode[2]);
  swreq_c: cover property (wr_edge && io_address_in == `DMAC_PORT_REQUEST);
endmodule

// ==== test/dmac_sink_model.sv ====
// Transfer stream receiver model with a stall control
`timescale 1ns/1ps

module dmac_sink_model
  import dmac_pkg::*;
(
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic [1:0] channel_in,
  input wire logic [15:0] address_in,
  input wire logic last_in,
  output logic ready_out
);
  // Entry layout: last, channel, address
  logic [18:0] got_q[$];

  // Ready drops for as long as the bench asks, with no grace cycle
  assign ready_out = !stall_in;

  always @(posedge clk_in)
  begin
    if (valid_in === 1'b1 && ready_out)
    begin
      got_q.push_back({last_in, channel_in, address_in});
    end
  end
endmodule

// ==== test/four_channel_dma_register_interface_tb.sv ====
// Self-checking bench for the DMA register interface
`timescale 1ns/1ps

module four_channel_dma_register_interface_tb;
  import dmac_pkg::*;
  logic clk_in = 0, reset_in = 1, wr_n = 1, rd_n = 1, tick = 0, stall = 0;
  logic [3:0] addr = 4'h0, req = 4'h0, ack;
  logic [7:0] wdata = 8'h00, dout, row;
  logic oe_n, strobe, xv, xr, xl, ext, comp;
  logic [1:0] xc;
  logic [15:0] xa;
  int n_fail = 0, check_count = 0;

  dmac_regs dut (.clk_in(clk_in), .reset_in(reset_in),
    .io_address_in(addr), .io_data_in(wdata),
    .io_write_strobe_n_in(wr_n), .io_read_strobe_n_in(rd_n),
    .io_data_out(dout), .io_data_oe_n_out(oe_n),
    .channel_request_in(req), .channel_acknowledge_out(ack),
    .refresh_tick_in(tick), .refresh_row_out(row),
    .refresh_strobe_out(strobe), .xfer_valid_out(xv),
    .xfer_ready_in(xr), .xfer_channel_out(xc), .xfer_address_out(xa),
    .xfer_last_out(xl), .mem_write_extended_out(ext),
    .mem_timing_compressed_out(comp));

  dmac_sink_model sink (.clk_in(clk_in), .stall_in(stall), .valid_in(xv),
    .channel_in(xc), .address_in(xa), .last_in(xl), .ready_out(xr));

  initial
  begin
    forever #2 clk_in = ~clk_in;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [18:0] exp,
                     input logic [18:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // Strobes low four clocks, then high long enough for the synchroniser
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr_n = 0;
    repeat (4) @(negedge clk_in);
    wr_n = 1;
    repeat (6) @(negedge clk_in);
  endtask

  // Never aimed at ports 9 or A
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    rd_n = 0;
    repeat (4) @(negedge clk_in);
    rd_n = 1;
    repeat (6) @(negedge clk_in);
    d = dout;
  endtask

  task automatic rchk(input string what, input logic [3:0] a,
                      input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {11'h0, exp}, {11'h0, d});
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_soft_request();
    rchk("status_reset", 4'h8, 8'h00);
    wr(4'h9, 8'hff);
    rchk("status_swreq_set", 4'h8, 8'h80);
    wr(4'h9, 8'hfb);
    rchk("status_swreq_clr", 4'h8, 8'h00);
  endtask

  task automatic t_regs();
    for (int c = 0; c < 4; c++)
    begin
      wr(4'hc, 8'h00);
      wr(4'(2 * c), 8'(8'h10 + c));
      wr(4'(2 * c), 8'(8'ha0 + c));
      wr(4'(2 * c + 1), 8'h05);
      wr(4'(2 * c + 1), 8'(c));
      rchk("addr_lo", 4'(2 * c), 8'(8'h10 + c));
      rchk("addr_hi", 4'(2 * c), 8'(8'ha0 + c));
      rchk("count_lo", 4'(2 * c + 1), 8'h05);
      rchk("count_hi", 4'(2 * c + 1), 8'(c));
    end
    wr(4'h0, 8'h55);
    wr(4'hc, 8'h00);
    rchk("ptr_cleared", 4'h0, 8'h55);
  endtask

  task automatic t_polarity();
    wr(4'h8, 8'h40);
    rchk("req_active_low", 4'h8, 8'hf0);
    wr(4'h8, 8'h80);
    chk("ack_high_idle", 19'h0, {15'h0, ack});
    wr(4'h8, 8'h00);
    chk("ack_low_idle", 19'hf, {15'h0, ack});
  endtask

  task automatic t_timing();
    wr(4'h8, 8'h20);
    chk("ext_write", 19'h2, {17'h0, ext, comp});
    wr(4'h8, 8'h28);
    chk("compressed", 19'h1, {17'h0, ext, comp});
    wr(4'h8, 8'h09);
    chk("m2m_no_compress", 19'h0, {18'h0, comp});
    wr(4'h8, 8'h00);
  endtask

  task automatic t_refresh();
    logic [7:0] r0;
    int n;
    r0 = row;
    tick = 1;
    n = 0;
    while (strobe !== 1'b1 && n < 20)
    begin
      @(negedge clk_in);
      n++;
    end
    chk("refresh_pulse", 19'h1, {18'h0, strobe});
    chk("refresh_row", {11'h0, 8'(r0 + 1)}, {11'h0, row});
    tick = 0;
    repeat (8) @(negedge clk_in);
  endtask

  // Receiver stalls while four words are requested: none may be lost
  task automatic t_transfer();
    int n;
    sink.got_q.delete();
    wr(4'hc, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h2, 8'h20);
    wr(4'h3, 8'h03);
    wr(4'h3, 8'h00);
    wr(4'hb, 8'h05);
    stall = 1;
    wr(4'ha, 8'h01);
    req[1] = 1;
    repeat (60) @(negedge clk_in);
    chk("stalled_words", 19'h0, 19'(sink.got_q.size()));
    stall = 0;
    n = 0;
    while (sink.got_q.size() < 4 && n < 300)
    begin
      @(negedge clk_in);
      n++;
    end
    req[1] = 0;
    repeat (20) @(negedge clk_in);
    chk("word_total", 19'h4, 19'(sink.got_q.size()));
    for (int i = 0; i < sink.got_q.size() && i < 4; i++)
      chk("word", {i == 3, 2'h1, 16'(16'h2000 + i)}, sink.got_q[i]);
    rchk("status_tc", 4'h8, 8'h02);
    rchk("status_tc_cleared", 4'h8, 8'h00);
  endtask

  task automatic t_mask_disable();
    sink.got_q.delete();
    wr(4'hc, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'ha, 8'h02);
    wr(4'ha, 8'hfe);
    req[2] = 1;
    repeat (40) @(negedge clk_in);
    chk("masked_words", 19'h0, 19'(sink.got_q.size()));
    wr(4'h8, 8'h04);
    wr(4'ha, 8'h02);
    repeat (40) @(negedge clk_in);
    chk("disabled_words", 19'h0, 19'(sink.got_q.size()));
    wr(4'h8, 8'h00);
    req[2] = 0;
    repeat (20) @(negedge clk_in);
    chk("enabled_words", 19'h1, 19'(sink.got_q.size()));
    if (sink.got_q.size() > 0)
      chk("single_word", {1'b1, 2'h2, 16'ha212}, sink.got_q[0]);
  endtask

  // Channel 3 single, decrement, auto-init; then channel 0 address hold
  task automatic t_modes();
    sink.got_q.delete();
    wr(4'hc, 8'h00);
    wr(4'h7, 8'h01);
    wr(4'h7, 8'h00);
    wr(4'hb, 8'h73);
    wr(4'ha, 8'h03);
    wr(4'h9, 8'h07);
    repeat (40) @(negedge clk_in);
    chk("auto_words", 19'h2, 19'(sink.got_q.size()));
    if (sink.got_q.size() == 2)
    begin
      chk("auto_first", {1'b0, 2'h3, 16'ha313}, sink.got_q[0]);
      chk("auto_second", {1'b1, 2'h3, 16'ha312}, sink.got_q[1]);
    end
    rchk("auto_reload", 4'h6, 8'h13);
    rchk("status_two_tc", 4'h8, 8'h0c);
    sink.got_q.delete();
    wr(4'h8, 8'h03);
    wr(4'hc, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'ha, 8'h00);
    wr(4'h9, 8'h04);
    repeat (40) @(negedge clk_in);
    chk("hold_words", 19'h1, 19'(sink.got_q.size()));
    rchk("hold_addr", 4'h0, 8'h55);
    wr(4'h8, 8'h00);
  endtask

  task automatic t_master_clear();
    wr(4'h8, 8'h80);
    wr(4'hd, 8'h00);
    chk("ack_after_clear", 19'hf, {15'h0, ack});
    rchk("status_after_clear", 4'h8, 8'h00);
    rchk("temp_after_clear", 4'hd, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge clk_in);
    reset_in = 0;
    repeat (4) @(negedge clk_in);
    t_soft_request();
    t_regs();
    t_polarity();
    t_timing();
    t_refresh();
    t_transfer();
    t_mask_disable();
    t_modes();
    t_master_clear();
    end_of_test();
  end

  // Whole run needs about 1300 clocks; allow a wide margin
  initial
  begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule
